// >>> verilog/alub_defines.vh
// constants for the arithmetic, logic and branch execute unit
`ifndef ALUB_DEFINES_VH
`define ALUB_DEFINES_VH
// ----------------------------------------
// operation codes from the fetch stage
// ----------------------------------------
`define ALUB_OP_ADD_REGS 6'h00
`define ALUB_OP_ADD_CARRY 6'h01
`define ALUB_OP_ADD_WORD_IMM 6'h02
`define ALUB_OP_SUB_WORD_IMM 6'h03
`define ALUB_OP_SUB_REGS 6'h04
`define ALUB_OP_SUB_IMM 6'h05
`define ALUB_OP_SUB_WITH_CARRY 6'h06
`define ALUB_OP_SUB_CONST_CARRY 6'h07
`define ALUB_OP_AND_REGS 6'h08
`define ALUB_OP_AND_IMM 6'h09
`define ALUB_OP_OR_REGS 6'h0A
`define ALUB_OP_OR_IMMEDIATE 6'h0B
`define ALUB_OP_EXCLUSIVE_OR 6'h0C
`define ALUB_OP_SET_BITS 6'h0D
`define ALUB_OP_CLEAR_BITS 6'h0E
`define ALUB_OP_TEST_REGISTER 6'h0F
`define ALUB_OP_MUL_UU 6'h10
`define ALUB_OP_MUL_SS 6'h11
`define ALUB_OP_MUL_SU 6'h12
`define ALUB_OP_FMUL_UU 6'h13
`define ALUB_OP_FMUL_SS 6'h14
`define ALUB_OP_FMUL_SU 6'h15
`define ALUB_OP_INDIRECT_CALL 6'h16
`define ALUB_OP_COMPARE_REGS 6'h17
`define ALUB_OP_COMPARE_CARRY 6'h18
`define ALUB_OP_COMPARE_IMM 6'h19
`define ALUB_OP_COMPARE_SKIP_EQ 6'h1A
`define ALUB_OP_SKIP_REG_CLEAR 6'h1B
`define ALUB_OP_SKIP_REG_SET 6'h1C
`define ALUB_OP_SKIP_IO_CLEAR 6'h1D
`define ALUB_OP_SKIP_IO_SET 6'h1E
`define ALUB_OP_BRANCH_STAT_SET 6'h1F
`define ALUB_OP_BRANCH_STAT_CLEAR 6'h20
`define ALUB_OP_BRANCH_SIGNED_GE 6'h21
`define ALUB_OP_BRANCH_SIGNED_LT 6'h22
`define ALUB_OP_BRANCH_UNSIGNED_GE 6'h23
`define ALUB_OP_BRANCH_UNSIGNED_LT 6'h24
`define ALUB_OP_BRANCH_HALF_SET 6'h25
`define ALUB_OP_BRANCH_HALF_CLEAR 6'h26
`define ALUB_OP_BRANCH_TBIT_SET 6'h27
`define ALUB_OP_BRANCH_TBIT_CLEAR 6'h28
`define ALUB_OP_BRANCH_OVF_SET 6'h29
// ----------------------------------------
// status flag bit positions
// ----------------------------------------
`define ALUB_FLAG_C 0
`define ALUB_FLAG_Z 1
`define ALUB_FLAG_N 2
`define ALUB_FLAG_V 3
`define ALUB_FLAG_S 4
`define ALUB_FLAG_H 5
`define ALUB_FLAG_T 6
`define ALUB_FLAG_I 7
// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define ALUB_ADDR_CTRL 12'h000
`define ALUB_ADDR_FLAGS 12'h004
`define ALUB_ADDR_PROG_CNT 12'h008
`define ALUB_ADDR_INFO 12'h00C
`define ALUB_ADDR_GPR_BASE 12'h080
`define ALUB_CTRL_RUN 0
// ----------------------------------------
// reset values, cycle counts and Z pointer register numbers
// ----------------------------------------
`define ALUB_RST_CTRL 1'h0
`define ALUB_RST_FLAGS 8'h00
`define ALUB_CYC_SINGLE 2'h1
`define ALUB_CYC_DOUBLE 2'h2
`define ALUB_CYC_TRIPLE 2'h3
`define ALUB_ZPTR_LO 5'h1E
`define ALUB_ZPTR_HI 5'h1F
`endif

// >>> verilog/alub_execute.v
// execute unit for arithmetic, logic, multiply, call, skip and branch
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "alub_defines.vh"

module alub_execute #(
   parameter PC_W = 16
) (
   // clock and reset
   input wire core_clk_i,
   input wire sys_rst_i,
   // decoded instruction from fetch
   input wire instr_valid_i,
   input wire [5:0] instr_op_i,
   input wire [4:0] instr_dst_i,
   input wire [4:0] instr_src_i,
   input wire [7:0] instr_imm_i,
   input wire [2:0] instr_bit_i,
   input wire next_two_word_i,
   input wire io_bit_value_i,
   output reg instr_ready_o,
   output reg flush_o,
   output reg [PC_W-1:0] program_counter_o,
   output reg [7:0] status_flags_o,
   // apb slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o
);

   // ----------------------------------------
   // flag helpers
   // ----------------------------------------
   // returns {h, v, c} for r = a + b (+ carry)
   function [2:0] add_flags;
      input [7:0] a;
      input [7:0] b;
      input [7:0] r;
      begin
         add_flags[2] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
         add_flags[1] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
         add_flags[0] = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
      end
   endfunction

   // returns {h, v, c} for r = a - b (- carry)
   function [2:0] sub_flags;
      input [7:0] a;
      input [7:0] b;
      input [7:0] r;
      begin
         sub_flags[2] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
         sub_flags[1] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
         sub_flags[0] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      end
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg [7:0] gpr_q [0:31];
   reg [7:0] flags_q;
   reg [PC_W-1:0] pc_q;
   reg run_q;
   reg [1:0] busy_q;
   reg [1:0] last_cyc_q;
   reg [1:0] busy_d;
   reg ready_d;
   integer i;

   wire accept = instr_valid_i & instr_ready_o;
   wire [7:0] op_a = gpr_q[instr_dst_i];
   wire [7:0] op_b = gpr_q[instr_src_i];
   wire [7:0] op_k = instr_imm_i;
   wire carry_in = flags_q[`ALUB_FLAG_C];
   wire [4:0] dst_hi = instr_dst_i + 5'h01;
   wire [15:0] word_in = {gpr_q[dst_hi], op_a};
   wire [15:0] word_k = {10'h000, op_k[5:0]};
   wire [PC_W-1:0] zptr = {gpr_q[`ALUB_ZPTR_HI], gpr_q[`ALUB_ZPTR_LO]};
   wire [PC_W-1:0] br_off = {{(PC_W-7){op_k[6]}}, op_k[6:0]};

   // multiply operand signedness
   wire mul_sa = (instr_op_i == `ALUB_OP_MUL_SS) ||
      (instr_op_i == `ALUB_OP_MUL_SU) || (instr_op_i == `ALUB_OP_FMUL_SS) ||
      (instr_op_i == `ALUB_OP_FMUL_SU);
   wire mul_sb = (instr_op_i == `ALUB_OP_MUL_SS) ||
      (instr_op_i == `ALUB_OP_FMUL_SS);
   wire signed [17:0] mul_full = $signed({mul_sa & op_a[7], op_a}) *
      $signed({mul_sb & op_b[7], op_b});
   wire [15:0] mul_prod = mul_full[15:0];

   // ----------------------------------------
   // execute decode
   // ----------------------------------------
   reg [7:0] res8;
   reg [15:0] res16;
   reg [8:0] tmp9;
   reg [16:0] tmp17;
   reg [2:0] hvc;
   reg wr8;
   reg wr16;
   reg wr_mul;
   reg [7:0] flags_n;
   reg jump;
   reg [PC_W-1:0] pc_n;
   reg [1:0] cyc;
   reg cond;
   reg skip;

   always @* begin
      res8 = 8'h00;
      res16 = 16'h0000;
      tmp9 = 9'h000;
      tmp17 = 17'h00000;
      hvc = 3'h0;
      wr8 = 1'b0;
      wr16 = 1'b0;
      wr_mul = 1'b0;
      flags_n = flags_q;
      jump = 1'b0;
      cond = 1'b0;
      skip = 1'b0;
      pc_n = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
      cyc = `ALUB_CYC_SINGLE;
      case (instr_op_i)
         `ALUB_OP_ADD_REGS, `ALUB_OP_ADD_CARRY: begin
            tmp9 = {1'b0, op_a} + {1'b0, op_b} +
               {8'h00, carry_in & (instr_op_i == `ALUB_OP_ADD_CARRY)};
            res8 = tmp9[7:0];
            hvc = add_flags(op_a, op_b, res8);
            wr8 = 1'b1;
            flags_n[`ALUB_FLAG_H] = hvc[2];
            flags_n[`ALUB_FLAG_V] = hvc[1];
            flags_n[`ALUB_FLAG_C] = hvc[0];
            flags_n[`ALUB_FLAG_N] = res8[7];
            flags_n[`ALUB_FLAG_Z] = (res8 == 8'h00);
         end
         `ALUB_OP_SUB_REGS, `ALUB_OP_SUB_IMM, `ALUB_OP_SUB_WITH_CARRY,
         `ALUB_OP_SUB_CONST_CARRY, `ALUB_OP_COMPARE_REGS,
         `ALUB_OP_COMPARE_CARRY, `ALUB_OP_COMPARE_IMM: begin
            if ((instr_op_i == `ALUB_OP_SUB_REGS) ||
               (instr_op_i == `ALUB_OP_SUB_WITH_CARRY) ||
               (instr_op_i == `ALUB_OP_COMPARE_REGS) ||
               (instr_op_i == `ALUB_OP_COMPARE_CARRY))
               tmp9 = {1'b0, op_b};
            else
               tmp9 = {1'b0, op_k};
            cond = (instr_op_i == `ALUB_OP_SUB_WITH_CARRY) ||
               (instr_op_i == `ALUB_OP_SUB_CONST_CARRY) ||
               (instr_op_i == `ALUB_OP_COMPARE_CARRY);
            res8 = op_a - tmp9[7:0] - {7'h00, carry_in & cond};
            hvc = sub_flags(op_a, tmp9[7:0], res8);
            // compares leave the destination untouched
            wr8 = (instr_op_i != `ALUB_OP_COMPARE_REGS) &&
               (instr_op_i != `ALUB_OP_COMPARE_CARRY) &&
               (instr_op_i != `ALUB_OP_COMPARE_IMM);
            flags_n[`ALUB_FLAG_H] = hvc[2];
            flags_n[`ALUB_FLAG_V] = hvc[1];
            flags_n[`ALUB_FLAG_C] = hvc[0];
            flags_n[`ALUB_FLAG_N] = res8[7];
            // chained forms keep zero only if it was already set
            flags_n[`ALUB_FLAG_Z] = (res8 == 8'h00) &
               (~cond | flags_q[`ALUB_FLAG_Z]);
            cond = 1'b0;
         end
         `ALUB_OP_ADD_WORD_IMM, `ALUB_OP_SUB_WORD_IMM: begin
            if (instr_op_i == `ALUB_OP_ADD_WORD_IMM) begin
               tmp17 = {1'b0, word_in} + {1'b0, word_k};
               res16 = tmp17[15:0];
               flags_n[`ALUB_FLAG_V] = ~word_in[15] & res16[15];
               flags_n[`ALUB_FLAG_C] = ~res16[15] & word_in[15];
            end else begin
               tmp17 = {1'b0, word_in} - {1'b0, word_k};
               res16 = tmp17[15:0];
               flags_n[`ALUB_FLAG_V] = word_in[15] & ~res16[15];
               flags_n[`ALUB_FLAG_C] = res16[15] & ~word_in[15];
            end
            wr16 = 1'b1;
            cyc = `ALUB_CYC_DOUBLE;
            flags_n[`ALUB_FLAG_N] = res16[15];
            flags_n[`ALUB_FLAG_Z] = (res16 == 16'h0000);
            flags_n[`ALUB_FLAG_S] = res16[15] ^ flags_n[`ALUB_FLAG_V];
         end
         `ALUB_OP_AND_REGS, `ALUB_OP_AND_IMM, `ALUB_OP_OR_REGS,
         `ALUB_OP_OR_IMMEDIATE, `ALUB_OP_EXCLUSIVE_OR, `ALUB_OP_SET_BITS,
         `ALUB_OP_CLEAR_BITS, `ALUB_OP_TEST_REGISTER: begin
            case (instr_op_i)
               `ALUB_OP_AND_REGS: res8 = op_a & op_b;
               `ALUB_OP_AND_IMM: res8 = op_a & op_k;
               `ALUB_OP_OR_REGS: res8 = op_a | op_b;
               `ALUB_OP_OR_IMMEDIATE: res8 = op_a | op_k;
               `ALUB_OP_EXCLUSIVE_OR: res8 = op_a ^ op_b;
               `ALUB_OP_SET_BITS: res8 = op_a | op_k;
               `ALUB_OP_CLEAR_BITS: res8 = op_a & (8'hFF - op_k);
               default: res8 = op_a & op_a;
            endcase
            wr8 = 1'b1;
            flags_n[`ALUB_FLAG_V] = 1'b0;
            flags_n[`ALUB_FLAG_N] = res8[7];
            flags_n[`ALUB_FLAG_Z] = (res8 == 8'h00);
         end
         `ALUB_OP_MUL_UU, `ALUB_OP_MUL_SS, `ALUB_OP_MUL_SU: begin
            res16 = mul_prod;
            wr_mul = 1'b1;
            cyc = `ALUB_CYC_DOUBLE;
            flags_n[`ALUB_FLAG_C] = mul_prod[15];
            flags_n[`ALUB_FLAG_Z] = (mul_prod == 16'h0000);
         end
         `ALUB_OP_FMUL_UU, `ALUB_OP_FMUL_SS, `ALUB_OP_FMUL_SU: begin
            res16 = {mul_prod[14:0], 1'b0};
            wr_mul = 1'b1;
            cyc = `ALUB_CYC_DOUBLE;
            flags_n[`ALUB_FLAG_C] = mul_prod[15];
            flags_n[`ALUB_FLAG_Z] = (res16 == 16'h0000);
         end
         `ALUB_OP_INDIRECT_CALL: begin
            jump = 1'b1;
            pc_n = zptr;
            cyc = `ALUB_CYC_TRIPLE;
         end
         `ALUB_OP_COMPARE_SKIP_EQ, `ALUB_OP_SKIP_REG_CLEAR,
         `ALUB_OP_SKIP_REG_SET, `ALUB_OP_SKIP_IO_CLEAR,
         `ALUB_OP_SKIP_IO_SET: begin
            case (instr_op_i)
               `ALUB_OP_COMPARE_SKIP_EQ: skip = (op_a == op_b);
               `ALUB_OP_SKIP_REG_CLEAR: skip = ~op_b[instr_bit_i];
               `ALUB_OP_SKIP_REG_SET: skip = op_b[instr_bit_i];
               `ALUB_OP_SKIP_IO_CLEAR: skip = ~io_bit_value_i;
               default: skip = io_bit_value_i;
            endcase
            if (skip) begin
               jump = 1'b1;
               if (next_two_word_i) begin
                  pc_n = pc_q + {{(PC_W-2){1'b0}}, 2'h3};
                  cyc = `ALUB_CYC_TRIPLE;
               end else begin
                  pc_n = pc_q + {{(PC_W-2){1'b0}}, 2'h2};
                  cyc = `ALUB_CYC_DOUBLE;
               end
            end
         end
         `ALUB_OP_BRANCH_STAT_SET, `ALUB_OP_BRANCH_STAT_CLEAR,
         `ALUB_OP_BRANCH_SIGNED_GE, `ALUB_OP_BRANCH_SIGNED_LT,
         `ALUB_OP_BRANCH_UNSIGNED_GE, `ALUB_OP_BRANCH_UNSIGNED_LT,
         `ALUB_OP_BRANCH_HALF_SET, `ALUB_OP_BRANCH_HALF_CLEAR,
         `ALUB_OP_BRANCH_TBIT_SET, `ALUB_OP_BRANCH_TBIT_CLEAR,
         `ALUB_OP_BRANCH_OVF_SET: begin
            case (instr_op_i)
               `ALUB_OP_BRANCH_STAT_SET:
                  cond = flags_q[instr_bit_i];
               `ALUB_OP_BRANCH_STAT_CLEAR:
                  cond = ~flags_q[instr_bit_i];
               `ALUB_OP_BRANCH_SIGNED_GE: cond = ~(flags_q[`ALUB_FLAG_N] ^
                  flags_q[`ALUB_FLAG_V]);
               `ALUB_OP_BRANCH_SIGNED_LT: cond = flags_q[`ALUB_FLAG_N] ^
                  flags_q[`ALUB_FLAG_V];
               `ALUB_OP_BRANCH_UNSIGNED_GE:
                  cond = ~flags_q[`ALUB_FLAG_C];
               `ALUB_OP_BRANCH_UNSIGNED_LT:
                  cond = flags_q[`ALUB_FLAG_C];
               `ALUB_OP_BRANCH_HALF_SET:
                  cond = flags_q[`ALUB_FLAG_H];
               `ALUB_OP_BRANCH_HALF_CLEAR:
                  cond = ~flags_q[`ALUB_FLAG_H];
               `ALUB_OP_BRANCH_TBIT_SET:
                  cond = flags_q[`ALUB_FLAG_T];
               `ALUB_OP_BRANCH_TBIT_CLEAR:
                  cond = ~flags_q[`ALUB_FLAG_T];
               default: cond = flags_q[`ALUB_FLAG_V];
            endcase
            if (cond) begin
               jump = 1'b1;
               pc_n = pc_q + br_off + {{(PC_W-1){1'b0}}, 1'b1};
               cyc = `ALUB_CYC_DOUBLE;
            end
         end
         default: begin
            cyc = `ALUB_CYC_SINGLE;
         end
      endcase
   end

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire apb_done = psel_i & penable_i & pready_o;
   wire apb_wr = apb_done & pwrite_i;
   wire gpr_hit = (paddr_i[11:7] == 5'h01) & (paddr_i[1:0] == 2'h0);
   wire [4:0] gpr_idx = paddr_i[6:2];
   wire ctrl_hit = (paddr_i == `ALUB_ADDR_CTRL);
   wire flags_hit = (paddr_i == `ALUB_ADDR_FLAGS);
   wire pc_hit = (paddr_i == `ALUB_ADDR_PROG_CNT);
   wire info_hit = (paddr_i == `ALUB_ADDR_INFO);
   wire any_hit = gpr_hit | ctrl_hit | flags_hit | pc_hit | info_hit;
   reg [31:0] rd_mux;

   always @* begin
      rd_mux = 32'h00000000;
      if (ctrl_hit)
         rd_mux = {31'h00000000, run_q};
      else if (flags_hit)
         rd_mux = {24'h000000, flags_q};
      else if (pc_hit)
         rd_mux = {{(32-PC_W){1'b0}}, pc_q};
      else if (info_hit)
         rd_mux = {26'h0000000, last_cyc_q, busy_q, 1'b0, instr_ready_o};
      else if (gpr_hit)
         rd_mux = {24'h000000, gpr_q[gpr_idx]};
   end

   always @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h00000000;
      end else begin
         pready_o <= psel_i & penable_i & ~pready_o;
         pslverr_o <= psel_i & penable_i & ~pready_o & ~any_hit;
         if (psel_i & penable_i & ~pready_o & ~pwrite_i)
            prdata_o <= rd_mux;
      end
   end

   // ----------------------------------------
   // issue control
   // ----------------------------------------
   always @* begin
      if (accept)
         busy_d = cyc - 2'h1;
      else if (busy_q != 2'h0)
         busy_d = busy_q - 2'h1;
      else
         busy_d = 2'h0;
      ready_d = run_q & (busy_d == 2'h0);
   end

   // ----------------------------------------
   // architectural state
   // ----------------------------------------
   always @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (i = 0; i < 32; i = i + 1)
            gpr_q[i] <= 8'h00;
         flags_q <= `ALUB_RST_FLAGS;
         pc_q <= {PC_W{1'b0}};
         run_q <= `ALUB_RST_CTRL;
         busy_q <= 2'h0;
         last_cyc_q <= 2'h0;
         instr_ready_o <= 1'b0;
         flush_o <= 1'b0;
         program_counter_o <= {PC_W{1'b0}};
         status_flags_o <= `ALUB_RST_FLAGS;
      end else begin
         // software access first, the core wins a collision
         if (apb_wr & ctrl_hit)
            run_q <= pwdata_i[`ALUB_CTRL_RUN];
         if (apb_wr & flags_hit)
            flags_q <= pwdata_i[7:0];
         if (apb_wr & pc_hit)
            pc_q <= pwdata_i[PC_W-1:0];
         if (apb_wr & gpr_hit)
            gpr_q[gpr_idx] <= pwdata_i[7:0];
         busy_q <= busy_d;
         flush_o <= accept & jump;
         if (accept) begin
            last_cyc_q <= cyc;
            flags_q <= flags_n;
            pc_q <= pc_n;
            if (wr8)
               gpr_q[instr_dst_i] <= res8;
            if (wr16) begin
               gpr_q[instr_dst_i] <= res16[7:0];
               gpr_q[dst_hi] <= res16[15:8];
            end
            if (wr_mul) begin
               gpr_q[0] <= res16[7:0];
               gpr_q[1] <= res16[15:8];
            end
         end
         instr_ready_o <= ready_d;
         program_counter_o <= accept ? pc_n :
            ((apb_wr & pc_hit) ? pwdata_i[PC_W-1:0] : pc_q);
         status_flags_o <= accept ? flags_n :
            ((apb_wr & flags_hit) ? pwdata_i[7:0] : flags_q);
      end
   end

endmodule // alub_execute

// >>> sim/alub_fetch_model.sv
// fetch stage model offering decoded instructions
`timescale 1ns/1ps
module alub_fetch_model (
   // handshake
   input wire clk_i,
   input wire ready_i,
   // instruction
   output reg valid_o,
   output reg [5:0] op_o,
   output reg [4:0] dst_o,
   output reg [4:0] src_o,
   output reg [7:0] imm_o,
   output reg [2:0] bit_o,
   output reg two_o,
   output reg io_o
);
   initial begin
      valid_o = 1'b0;
      {op_o, dst_o, src_o, imm_o, bit_o, two_o, io_o} = 29'h0;
   end
   // ----------------------------------------
   // issue one word
   // ----------------------------------------
   task issue(input [28:0] w, output ok);
      integer n;
      begin
         n = 0;
         @(posedge clk_i);
         {op_o, dst_o, src_o, imm_o, bit_o, two_o, io_o} <= w;
         valid_o <= 1'b1;
         @(posedge clk_i);
         while (!ready_i && n < 20) begin
            n = n + 1;
            @(posedge clk_i);
         end
         ok = ready_i;
         valid_o <= 1'b0;
         {op_o, dst_o, src_o, imm_o, bit_o, two_o, io_o} <= ~w;
      end
   endtask
endmodule // alub_fetch_model

// >>> sim/alub_execute_chk.sv
// execute unit checker
`timescale 1ns/1ps
`include "alub_defines.vh"
module alub_execute_chk #(
   parameter PC_W = 16
) (
   // clock and reset
   input wire core_clk_i,
   input wire sys_rst_i,
   // instruction port
   input wire instr_valid_i,
   input wire [5:0] instr_op_i,
   input wire [4:0] instr_dst_i,
   input wire [4:0] instr_src_i,
   input wire [7:0] instr_imm_i,
   input wire [2:0] instr_bit_i,
   input wire next_two_word_i,
   input wire io_bit_value_i,
   input wire instr_ready_o,
   input wire flush_o,
   input wire [PC_W-1:0] program_counter_o,
   input wire [7:0] status_flags_o,
   // apb
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o
);
   wire [5:0] op = instr_op_i;
   wire tk = instr_valid_i & instr_ready_o;
   wire one_c = op < 6'h02 || (op > 6'h03 && op < 6'h10) ||
      (op > 6'h16 && op < 6'h1A);
   wire two_c = op == 6'h02 || op == 6'h03 || (op > 6'h0F && op < 6'h16);
   wire br = op >= `ALUB_OP_BRANCH_STAT_SET;
   wire sk = op >= `ALUB_OP_COMPARE_SKIP_EQ && !br;
   wire [PC_W-1:0] koff = {{(PC_W-7){instr_imm_i[6]}}, instr_imm_i[6:0]};
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   // ----------------------------------------
   // checks
   // ----------------------------------------
   one_cycle_a: assert property (tk && one_c |=> instr_ready_o && !flush_o)
      else $error("single cycle op stalled");
   two_cycle_a: assert property (tk && two_c |=> !instr_ready_o ##1 instr_ready_o)
      else $error("two cycle op timing");
   call_cycle_a: assert property (tk && op == `ALUB_OP_INDIRECT_CALL
      |=> !instr_ready_o [*2] ##1 instr_ready_o) else $error("call timing");
   branch_pc_a: assert property (tk && br |=> program_counter_o ==
      PC_W'($past(program_counter_o) + (flush_o ? $past(koff) + 1 : 1)))
      else $error("branch target wrong");
   branch_busy_a: assert property (tk && br |=>
      (instr_ready_o != flush_o) ##1 instr_ready_o) else $error("branch stall");
   skip_pc_a: assert property (tk && sk |=> program_counter_o ==
      PC_W'($past(program_counter_o) + (flush_o ? 2 + $past(next_two_word_i) : 1)))
      else $error("skip target wrong");
   skip_io_a: assert property (tk && op == `ALUB_OP_SKIP_IO_SET
      |=> flush_o == $past(io_bit_value_i)) else $error("io skip wrong");
   flags_keep_a: assert property (tk && op >= 6'h1A |=> $stable(status_flags_o))
      else $error("flags changed");
   flush_pulse_a: assert property (flush_o |=> !flush_o)
      else $error("flush too long");
   apb_err_a: assert property (psel_i && penable_i && pready_o && pslverr_o
      && !pwrite_i |-> prdata_o == 32'h0) else $error("bad error read");
   cover property (tk && br ##1 flush_o);
   cover property (tk && sk ##1 flush_o);
   cover property (tk && op == `ALUB_OP_INDIRECT_CALL);
   cover property (pready_o && pslverr_o);
endmodule // alub_execute_chk
bind alub_execute alub_execute_chk #(.PC_W(PC_W)) u_chk (.*);

// >>> sim/tb.sv
// bench for the execute unit
`timescale 1ns/1ps
`include "alub_defines.vh"
module tb;
   reg clk;
   reg rst = 1'b1;
   reg psel = 1'b0;
   reg pen = 1'b0;
   reg pwr = 1'b0;
   reg [11:0] pad = 12'h000;
   reg [31:0] pwd = 32'h0;
   wire [31:0] prd;
   wire prdy, perr, rdy, fl, vld, two, iob;
   wire [15:0] pco;
   wire [7:0] flg, imm;
   wire [5:0] op;
   wire [4:0] dst, src;
   wire [2:0] bsel;
   integer err_count = 0;
   integer check_count = 0;
   integer seed = 39;
   integer i, n;
   reg [31:0] q;
   reg e, ok, tw, iv;
   reg [7:0] a, b, f, k;
   reg [15:0] z, pc;
   reg [5:0] o;
   reg [4:0] d;
   reg [2:0] bt;
   reg [55:0] x;
   alub_execute u_alub_execute (.core_clk_i(clk), .sys_rst_i(rst),
      .instr_valid_i(vld), .instr_op_i(op), .instr_dst_i(dst),
      .instr_src_i(src), .instr_imm_i(imm), .instr_bit_i(bsel),
      .next_two_word_i(two), .io_bit_value_i(iob), .instr_ready_o(rdy),
      .flush_o(fl), .program_counter_o(pco), .status_flags_o(flg),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pad),
      .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr));
   alub_fetch_model u_alub_fetch_model (.clk_i(clk), .ready_i(rdy),
      .valid_o(vld), .op_o(op), .dst_o(dst), .src_o(src), .imm_o(imm),
      .bit_o(bsel), .two_o(two), .io_o(iob));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task check(input [63:0] s, input [63:0] w);
      begin
         check_count = check_count + 1;
         if (s !== w) begin
            err_count = err_count + 1;
            $display("[ERR] %0t got %h want %h", $time, s, w);
         end
      end
   endtask
   task final_report;
      begin
         if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task apb(input w, input [11:0] ad, input [31:0] dt);
      integer m;
      begin
         m = 0;
         @(posedge clk);
         psel <= 1'b1;
         pen <= 1'b0;
         pwr <= w;
         pad <= ad;
         pwd <= dt;
         @(posedge clk);
         pen <= 1'b1;
         @(posedge clk);
         while (!prdy && m < 20) begin
            m = m + 1;
            @(posedge clk);
         end
         q = prd;
         e = perr;
         check(m < 20, 1'b1);
         psel <= 1'b0;
         pen <= 1'b0;
      end
   endtask
   function [55:0] model(input [5:0] o, input [7:0] a, b, f, k,
      input [2:0] bt, input tw, io, input [15:0] z, pc);
      reg [8:0] s;
      reg [7:0] r, n, bb;
      reg [15:0] w, p, q;
      reg c, zc, t, bo;
      begin
         n = f;
         q = pc + 16'h1;
         t = 1'b0;
         p = 16'h0;
         w = {b, a};
         bb = (o == 6'h05 || o == 6'h07 || o == 6'h19) ? k : b;
         zc = o == 6'h06 || o == 6'h07 || o == 6'h18;
         c = f[0] & (zc || o == `ALUB_OP_ADD_CARRY);
         s = (o < 6'h02) ? a + b + c : {1'b0, a} - bb - c;
         r = s[7:0];
         bo = o < 6'h02 || (o > 6'h03 && o < 6'h10) || (o > 6'h16 && o < 6'h1A);
         if (bo && (o < 6'h08 || o > 6'h0F)) begin
            n[0] = s[8];
            n[5] = o < 6'h02 ? a[3] & bb[3] | bb[3] & ~r[3] | ~r[3] & a[3]
               : ~a[3] & bb[3] | bb[3] & r[3] | r[3] & ~a[3];
            n[3] = o < 6'h02 ? a[7] & bb[7] & ~r[7] | ~a[7] & ~bb[7] & r[7]
               : a[7] & ~bb[7] & ~r[7] | ~a[7] & bb[7] & r[7];
         end
         case (o)
            6'h08: r = a & b;
            6'h09: r = a & k;
            6'h0A: r = a | b;
            6'h0B, 6'h0D: r = a | k;
            6'h0C: r = a ^ b;
            6'h0E: r = a & (8'hFF - k);
            6'h0F: r = a & a;
            6'h1A: t = a == b;
            6'h1B: t = ~b[bt];
            6'h1C: t = b[bt];
            6'h1D: t = ~io;
            6'h1E: t = io;
            6'h1F: t = f[bt];
            6'h20: t = ~f[bt];
            6'h21: t = ~(f[2] ^ f[3]);
            6'h22: t = f[2] ^ f[3];
            6'h23: t = ~f[0];
            6'h24: t = f[0];
            6'h25: t = f[5];
            6'h26: t = ~f[5];
            6'h27: t = f[6];
            6'h28: t = ~f[6];
            6'h29: t = f[3];
            default: t = 1'b0;
         endcase
         if (o > 6'h07 && o < 6'h10)
            n[3] = 1'b0;
         if (bo) begin
            n[2] = r[7];
            n[1] = (r == 8'h0) & (~zc | f[1]);
            if (o < 6'h17)
               w[7:0] = r;
         end
         if (o == 6'h02 || o == 6'h03) begin
            w = o[0] ? {b, a} - k[5:0] : {b, a} + k[5:0];
            n[2] = w[15];
            n[1] = w == 16'h0;
            n[3] = o[0] ? b[7] & ~w[15] : ~b[7] & w[15];
            n[0] = o[0] ? w[15] & ~b[7] : b[7] & ~w[15];
            n[4] = n[2] ^ n[3];
         end
         if (o > 6'h0F && o < 6'h16) begin
            p = {{8{a[7] & o != 6'h10 & o != 6'h13}}, a} *
               {{8{b[7] & (o == 6'h11 || o == 6'h14)}}, b};
            n[0] = p[15];
            if (o > 6'h12)
               p = p << 1;
            n[1] = p == 16'h0;
         end
         if (o == `ALUB_OP_INDIRECT_CALL)
            q = z;
         if (t)
            q = o < 6'h1F ? pc + 16'h2 + tw : pc + {{9{k[6]}}, k[6:0]} + 16'h1;
         model = {w, p, n, q};
      end
   endfunction
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #800000;
      err_count = err_count + 1;
      final_report;
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
         apb(1'b0, i < 3 ? i * 4 : `ALUB_ADDR_GPR_BASE, 32'h0);
         check(q, 32'h0);
      end
      apb(1'b0, 12'h040, 32'h0);
      check({e, q}, {1'b1, 32'h0});
      apb(1'b1, `ALUB_ADDR_CTRL, 32'h1);
      for (i = 0; i < 300; i = i + 1) begin
         o = i < 42 ? i : $unsigned($random(seed)) % 42;
         {a, b, f, k} = $random(seed);
         {z, pc} = $random(seed);
         {d, bt, tw, iv} = $random(seed);
         d = 5'd24 + {3'b0, d[0], 1'b0};
         if (i % 4 == 0)
            b = a;
         if (i % 5 == 0)
            a = 8'h80;
         apb(1'b1, `ALUB_ADDR_GPR_BASE + {d, 2'b00}, a);
         apb(1'b1, `ALUB_ADDR_GPR_BASE + {d + 5'd1, 2'b00}, b);
         apb(1'b1, 12'h0F8, z[7:0]);
         apb(1'b1, 12'h0FC, z[15:8]);
         apb(1'b1, `ALUB_ADDR_FLAGS, f);
         apb(1'b1, `ALUB_ADDR_PROG_CNT, pc);
         u_alub_fetch_model.issue({o, d, d + 5'd1, k, bt, tw, iv}, ok);
         check(ok, 1'b1);
         n = 0;
         @(posedge clk);
         while (!rdy && n < 9) begin
            n = n + 1;
            @(posedge clk);
         end
         check(rdy, 1'b1);
         x = model(o, a, b, f, k, bt, tw, iv, z, pc);
         check(flg, x[23:16]);
         check(pco, x[15:0]);
         apb(1'b0, `ALUB_ADDR_GPR_BASE + {d, 2'b00}, 32'h0);
         check(q, x[47:40]);
         apb(1'b0, `ALUB_ADDR_GPR_BASE + {d + 5'd1, 2'b00}, 32'h0);
         check(q, x[55:48]);
         if (o > 6'h0F && o < 6'h16) begin
            apb(1'b0, `ALUB_ADDR_GPR_BASE, 32'h0);
            check(q, x[31:24]);
            apb(1'b0, `ALUB_ADDR_GPR_BASE + 12'h004, 32'h0);
            check(q, x[39:32]);
         end
      end
      final_report;
   end
endmodule // tb
